// [logic/rcm_pkg.sv]
// shared constants, field layouts and address map of the reference pre-divider and monitor
`default_nettype none
package rcm_pkg;
    localparam int NIN = 6;
    localparam int NPRE = 4;
    localparam int NDPLL = 3;
    localparam int NPROF = 4;
    localparam int CLK_PERIOD_NS = 4;
    localparam int ACT_PERIOD_MS = 128;
    localparam int ACT_PERIOD_CYC = ACT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int ACT_W = 25;
    localparam logic [11:0] DRIFT_PPM = 12'h1f4;

    localparam logic [7:0] A_GLOB = 8'h00;
    localparam logic [7:0] A_WIN = 8'h04;
    localparam logic [7:0] A_SEL = 8'h08;
    localparam logic [3:0] A_PROF_HI = 4'h1;
    localparam logic [2:0] IN_BLK0 = 3'h2;
    localparam logic [2:0] SUB_CFG = 3'h0;
    localparam logic [2:0] SUB_DLO = 3'h1;
    localparam logic [2:0] SUB_DHI = 3'h2;
    localparam logic [2:0] SUB_FRAC = 3'h3;
    localparam logic [2:0] SUB_EXP = 3'h4;
    localparam logic [2:0] SUB_STAT = 3'h5;

    localparam logic [3:0] RATE_8K = 4'h0;
    localparam logic [3:0] RATE_T1E1 = 4'h1;
    localparam logic [3:0] RATE_6M48 = 4'h2;
    localparam logic [3:0] RATE_2K = 4'h9;
    localparam logic [3:0] RATE_4K = 4'ha;
    localparam logic [3:0] RATE_1PPS = 4'hb;
    localparam logic [3:0] RATE_6M25 = 4'hc;

    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [1:0] PS_DIV5 = 2'h2;
    localparam logic [2:0] PS4_LAST = 3'h3;
    localparam logic [2:0] PS5_LAST = 3'h4;

    localparam logic [3:0] SEL_AUTO = 4'h0;
    localparam logic [3:0] SEL_F1 = 4'h3;
    localparam logic [3:0] SEL_F4 = 4'h6;
    localparam logic [3:0] SEL_F5 = 4'h9;
    localparam logic [3:0] SEL_F6 = 4'ha;
    localparam logic [3:0] SEL_BASE_LO = 4'h2;
    localparam logic [3:0] SEL_BASE_HI = 4'h4;

    typedef struct packed {
        logic [7:0] lenient_th;
        logic [7:0] strict_th;
        logic [3:0] scale;
        logic [1:0] rsvd;
        logic       telecom_rate;
        logic       mon_src_dpll1;
    } rcm_glob_s;

    typedef struct packed {
        logic [1:0] decay;
        logic [7:0] clear_lvl;
        logic [7:0] raise_lvl;
        logic [7:0] capacity;
    } rcm_prof_s;

    typedef struct packed {
        logic [5:0] rsvd;
        logic [1:0] prof_sel;
        logic [3:0] target_rate;
        logic       low_rate_lock;
        logic       direct_bypass;
        logic [1:0] high_rate_prescale_sel;
    } rcm_in_cfg_s;

    typedef struct packed {
        logic       qualified;
        logic       lenient_freq_alarm;
        logic       strict_freq_alarm;
        logic       inactivity_alarm;
        logic [7:0] bucket;
        logic [7:0] meas;
    } rcm_in_stat_s;
endpackage
`default_nettype wire

// [logic/rcm_top.sv]
// reference pre-dividers, activity and frequency monitors, selection decode, APB registers
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1: target-rate code chooses expected rate; others reserved
// R2: each input: fractional then integer divider
// R3: inputs 1-4 prescale by 4, 5 or bypass
// R4: low-rate inputs: software bypasses whole pre-divider; here low_rate_lock set runs the integer divider
// R5: bypass bits skip integer divider; here either bit set runs the integer divider, both low skip it
// R6: sync-paired inputs must skip integer divider
// R7: host writes factor low byte, then high
// R8: integer divider divides by factor plus one
// R9: fractional divider divides numerator over denominator
// R10: monitors always run; qualification to three DPLLs
// R11: drift over 500 ppm per 128 ms adds one
// R12: quiet decay period subtracts one from bucket
// R13: four profiles, two-bit selector per input
// R14: bucket saturates at profile capacity
// R15: inactivity alarm hysteresis on raise/clear levels
// R16: inactivity alarm removes input from selection
// R17: monitor reference: system clock or DPLL1
// R18: accept/reject limits from threshold nibbles times scale
// R19: frequency alarms set above reject, clear below accept
// R20: strict alarm disqualifies; lenient alarm does not
// R21: measured offset times scale gives ppm
// R22: selection codes: automatic or forced inputs
// R23: forced selection ignores qualification
// R24: new factor takes effect on high write
// R25: reset clears buckets and all alarms
module rcm_top #(
    parameter int ACT_PERIOD_CYC = rcm_pkg::ACT_PERIOD_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [5:0]  ref_inputs_i,
    input  wire logic        dpll1_out_i,
    output logic      [5:0]  div_clk_o,
    output logic      [5:0]  ref_qualified_o,
    output logic      [2:0]  sel_auto_o,
    output logic      [2:0]  sel_forced_o,
    output logic      [8:0]  sel_input_o
);
    localparam int NIN = rcm_pkg::NIN;

    rcm_pkg::rcm_glob_s   glob_r;
    logic [15:0]          win_len_r;
    logic [11:0]          sel_r;
    rcm_pkg::rcm_prof_s   prof_r [rcm_pkg::NPROF];
    rcm_pkg::rcm_in_cfg_s cfg_r [NIN];
    logic [7:0]           dlo_r [NIN];
    logic [14:0]          dfac_r [NIN];
    logic [15:0]          frac_p_r [NIN];
    logic [15:0]          frac_q_r [NIN];
    logic [15:0]          exp_r [NIN];
    rcm_pkg::rcm_in_stat_s stat_w [NIN];

    // bus decode
    wire logic       setup_w = psel_i & ~penable_i;
    wire logic       wr_w    = psel_i & penable_i & pwrite_i;
    wire logic       algn_w  = (paddr_i[1:0] == 2'h0);
    wire logic [2:0] blk_w   = paddr_i[7:5] - rcm_pkg::IN_BLK0;
    wire logic [2:0] sub_w   = paddr_i[4:2];
    wire logic [1:0] pidx_w  = paddr_i[3:2];
    wire logic       in_hit_w = algn_w && (paddr_i[7:6] != 2'h0) && (blk_w < 3'(NIN))
                                && (sub_w <= rcm_pkg::SUB_STAT);
    wire logic       prof_hit_w = algn_w && (paddr_i[7:4] == rcm_pkg::A_PROF_HI);
    wire logic       glob_hit_w = (paddr_i == rcm_pkg::A_GLOB);
    wire logic       win_hit_w  = (paddr_i == rcm_pkg::A_WIN);
    wire logic       sel_hit_w  = (paddr_i == rcm_pkg::A_SEL);
    wire logic       hit_w = in_hit_w | prof_hit_w | glob_hit_w | win_hit_w | sel_hit_w;

    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0;
        if (glob_hit_w) begin
            rd_data = 32'(glob_r);
        end else if (win_hit_w) begin
            rd_data = 32'(win_len_r);
        end else if (sel_hit_w) begin
            rd_data = 32'(sel_r);
        end else if (prof_hit_w) begin
            rd_data = 32'(prof_r[pidx_w]);
        end else if (in_hit_w) begin
            unique case (sub_w)
                rcm_pkg::SUB_CFG:  rd_data = 32'(cfg_r[blk_w]);
                rcm_pkg::SUB_DLO:  rd_data = 32'(dlo_r[blk_w]);
                rcm_pkg::SUB_DHI:  rd_data = 32'(dfac_r[blk_w][14:8]);
                rcm_pkg::SUB_FRAC: rd_data = {frac_q_r[blk_w], frac_p_r[blk_w]};
                rcm_pkg::SUB_EXP:  rd_data = 32'(exp_r[blk_w]);
                default:           rd_data = 32'(stat_w[blk_w]);
            endcase
        end
    end

    // zero-wait slave: answer is prepared in the setup cycle
    // pready never drops, so every access ends in its first access cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
        end else if (setup_w) begin
            prdata_o  <= rd_data;
            pready_o  <= 1'b1;
            pslverr_o <= ~hit_w;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            glob_r    <= '0;
            win_len_r <= 16'h0;
            sel_r     <= 12'h0;
            for (int k = 0; k < rcm_pkg::NPROF; k++) begin
                prof_r[k] <= '0;
            end
            for (int k = 0; k < NIN; k++) begin
                cfg_r[k]    <= '0;
                dlo_r[k]    <= 8'h0;
                dfac_r[k]   <= 15'h0;
                frac_p_r[k] <= 16'h0;
                frac_q_r[k] <= 16'h0;
                exp_r[k]    <= 16'h0;
            end
        end else if (wr_w) begin
            if (glob_hit_w) begin
                glob_r <= pwdata_i[23:0];
            end
            if (win_hit_w) begin
                win_len_r <= pwdata_i[15:0];
            end
            if (sel_hit_w) begin
                sel_r <= pwdata_i[11:0];
            end
            if (prof_hit_w) begin
                prof_r[pidx_w] <= pwdata_i[25:0]; // see R13
            end
            if (in_hit_w) begin
                unique case (sub_w)
                    rcm_pkg::SUB_CFG:  cfg_r[blk_w] <= pwdata_i[15:0];
                    rcm_pkg::SUB_DLO:  dlo_r[blk_w] <= pwdata_i[7:0]; // see R7
                    // high write commits both halves at once
                    rcm_pkg::SUB_DHI:  dfac_r[blk_w] <= {pwdata_i[6:0], dlo_r[blk_w]}; // see R24
                    rcm_pkg::SUB_FRAC: begin
                        frac_p_r[blk_w] <= pwdata_i[15:0];
                        frac_q_r[blk_w] <= pwdata_i[31:16];
                    end
                    rcm_pkg::SUB_EXP:  exp_r[blk_w] <= pwdata_i[15:0];
                    default:           ;
                endcase
            end
        end
    end

    // monitor reference ticks: every system clock or each DPLL1 output rising edge
    // dpll1 output passes the same two-flop synchroniser as the inputs
    logic [2:0]  dsy_r;
    logic [15:0] win_cnt_r;
    logic [rcm_pkg::ACT_W-1:0] act_cnt_r;
    wire logic ref_tick_w = glob_r.mon_src_dpll1 ? (dsy_r[1] & ~dsy_r[2]) : 1'b1; // see R17
    wire logic win_end_w  = ref_tick_w && (win_cnt_r == win_len_r);
    wire logic act_tick_w = (act_cnt_r == rcm_pkg::ACT_W'(ACT_PERIOD_CYC - 1)); // see R11
    wire logic [rcm_pkg::ACT_W-1:0] act_inc_w = act_cnt_r + rcm_pkg::ACT_W'(1);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dsy_r     <= 3'h0;
            win_cnt_r <= 16'h0;
            act_cnt_r <= '0;
        end else begin
            dsy_r     <= {dsy_r[1:0], dpll1_out_i};
            win_cnt_r <= win_end_w ? 16'h0 : win_cnt_r + 16'(ref_tick_w);
            act_cnt_r <= act_tick_w ? '0 : act_inc_w;
        end
    end

    for (genvar i = 0; i < NIN; i++) begin : g_in
        logic [2:0]  sy_r;
        logic [2:0]  pcnt_r;
        logic [16:0] facc_r;
        logic [14:0] icnt_r;
        logic [15:0] ecnt_r;
        logic [7:0]  meas_r;
        logic [7:0]  bkt_r;
        logic [2:0]  dcnt_r;
        logic        seen_r;
        logic        inact_r;
        logic        strict_r;
        logic        len_r;
        rcm_pkg::rcm_in_cfg_s c;
        rcm_pkg::rcm_prof_s   p;
        assign c = cfg_r[i];
        assign p = prof_r[c.prof_sel]; // see R13

        // sy_r[0] is only read by sy_r[1]
        wire logic edge_w = sy_r[1] & ~sy_r[2];
        wire logic ps_on  = (i < rcm_pkg::NPRE) && ((c.high_rate_prescale_sel == rcm_pkg::PS_DIV4)
                            || (c.high_rate_prescale_sel == rcm_pkg::PS_DIV5)); // see R2 R3
        wire logic [2:0] ps_last = (c.high_rate_prescale_sel == rcm_pkg::PS_DIV5) ?
                                   rcm_pkg::PS5_LAST : rcm_pkg::PS4_LAST;
        wire logic pre_ev = edge_w && (!ps_on || pcnt_r == ps_last); // see R3
        // fractional stage: q credits per input edge, one output per p credits
        // a p written below the running sum is drained over later events
        wire logic [16:0] fsum = facc_r + 17'(frac_q_r[i]);
        wire logic f_on   = (frac_p_r[i] != 16'h0);
        wire logic f_ev   = f_on ? (pre_ev && fsum >= 17'(frac_p_r[i])) : pre_ev; // see R9
        // both bypass bits low skip the integer stage; low_rate_lock set runs it, as direct_bypass does
        wire logic i_on   = c.direct_bypass | c.low_rate_lock; // see R5 R4 R6
        wire logic i_ev   = i_on ? (f_ev && icnt_r == dfac_r[i]) : f_ev; // see R8
        wire logic rate_ok = c.target_rate inside {rcm_pkg::RATE_8K, rcm_pkg::RATE_T1E1,
                             rcm_pkg::RATE_6M48, rcm_pkg::RATE_2K, rcm_pkg::RATE_4K,
                             rcm_pkg::RATE_1PPS, rcm_pkg::RATE_6M25}; // see R1

        // window result, in units of the ppm scale factor
        wire logic [15:0] dif = (ecnt_r >= exp_r[i]) ? ecnt_r - exp_r[i] : exp_r[i] - ecnt_r;
        wire logic [7:0]  m8  = (dif[15:8] != 8'h0) ? 8'hff : dif[7:0];
        wire logic [11:0] ppm = 12'(m8) * 12'(glob_r.scale); // see R21
        wire logic drift  = win_end_w && (ppm > rcm_pkg::DRIFT_PPM); // see R11
        wire logic ev_now = seen_r | drift;
        wire logic [8:0] s_rej = 9'(glob_r.strict_th[3:0]) + 9'h001; // see R18
        wire logic [8:0] s_acc = 9'(glob_r.strict_th[7:4]) + 9'h001;
        wire logic [8:0] l_rej = 9'(glob_r.lenient_th[3:0]) + 9'h001;
        wire logic [8:0] l_acc = 9'(glob_r.lenient_th[7:4]) + 9'h001;
        wire logic [3:0] dper  = 4'h1 << p.decay;
        wire logic [2:0] dlast = 3'(dper - 4'h1);

        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                sy_r      <= 3'h0;
                pcnt_r    <= 3'h0;
                facc_r    <= 17'h0;
                icnt_r    <= 15'h0;
                div_clk_o[i] <= 1'b0;
            end else begin
                sy_r <= {sy_r[1:0], ref_inputs_i[i]};
                if (edge_w) begin
                    pcnt_r <= (pcnt_r == ps_last || !ps_on) ? 3'h0 : pcnt_r + 3'h1;
                end
                if (pre_ev && f_on) begin
                    facc_r <= f_ev ? fsum - 17'(frac_p_r[i]) : fsum;
                end
                if (f_ev && i_on) begin
                    icnt_r <= (icnt_r >= dfac_r[i]) ? 15'h0 : icnt_r + 15'h1;
                end
                if (i_ev) begin
                    div_clk_o[i] <= ~div_clk_o[i];
                end
            end
        end

        // monitors never stop, whatever the selection mode
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                ecnt_r   <= 16'h0;
                meas_r   <= 8'h0;
                strict_r <= 1'b0; // see R25
                len_r    <= 1'b0;
                seen_r   <= 1'b0;
                bkt_r    <= 8'h0;
                dcnt_r   <= 3'h0;
                inact_r  <= 1'b0;
                ref_qualified_o[i] <= 1'b0;
            end else begin
                if (win_end_w) begin
                    ecnt_r <= 16'(i_ev);
                    meas_r <= m8;
                    if (9'(m8) > s_rej) begin
                        strict_r <= 1'b1; // see R19
                    end else if (9'(m8) < s_acc) begin
                        strict_r <= 1'b0;
                    end
                    if (9'(m8) > l_rej) begin
                        len_r <= 1'b1; // see R19
                    end else if (9'(m8) < l_acc) begin
                        len_r <= 1'b0;
                    end
                end else if (i_ev && ecnt_r != 16'hffff) begin
                    ecnt_r <= ecnt_r + 16'h1;
                end
                // a drift caught in the tick cycle belongs to the closing period
                seen_r <= act_tick_w ? 1'b0 : ev_now;
                if (act_tick_w) begin
                    if (ev_now) begin
                        dcnt_r <= 3'h0;
                        if (bkt_r < p.capacity) begin
                            bkt_r <= bkt_r + 8'h1; // see R11 R14
                        end
                    end else if (dcnt_r >= dlast) begin
                        dcnt_r <= 3'h0;
                        if (bkt_r != 8'h0) begin
                            bkt_r <= bkt_r - 8'h1; // see R12
                        end
                    end else begin
                        dcnt_r <= dcnt_r + 3'h1;
                    end
                end
                if (bkt_r > p.raise_lvl) begin
                    inact_r <= 1'b1; // see R15
                end else if (bkt_r < p.clear_lvl) begin
                    inact_r <= 1'b0;
                end
                // lenient alarm deliberately left out of qualification
                ref_qualified_o[i] <= ~inact_r & ~strict_r & rate_ok; // see R16 R20 R10
            end
        end

        assign stat_w[i] = {ref_qualified_o[i], len_r, strict_r, inact_r, bkt_r, meas_r};
    end

    for (genvar d = 0; d < rcm_pkg::NDPLL; d++) begin : g_sel
        wire logic [3:0] code = sel_r[4*d +: 4];
        wire logic f_lo = (code >= rcm_pkg::SEL_F1) && (code <= rcm_pkg::SEL_F4);
        wire logic f_hi = (code >= rcm_pkg::SEL_F5) && (code <= rcm_pkg::SEL_F6);
        wire logic [3:0] num = f_lo ? code - rcm_pkg::SEL_BASE_LO :
                               f_hi ? code - rcm_pkg::SEL_BASE_HI : 4'h0; // see R22

        // forced number is passed regardless of qualification
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                sel_auto_o[d]         <= 1'b0;
                sel_forced_o[d]       <= 1'b0;
                sel_input_o[3*d +: 3] <= 3'h0;
            end else begin
                sel_auto_o[d]         <= (code == rcm_pkg::SEL_AUTO); // see R22
                sel_forced_o[d]       <= f_lo | f_hi; // see R23
                sel_input_o[3*d +: 3] <= num[2:0];
            end
        end
    end
endmodule

`default_nettype wire

// [tb/rcm_top_chk.sv]
// concurrent checks on the register bus, divider outputs and selection decode ports
`timescale 1ns/100ps
`default_nettype none
module rcm_top_chk (
    input wire logic        ref_clk_i,
    input wire logic        rst_b_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [5:0]  ref_inputs_i,
    input wire logic [5:0]  div_clk_o,
    input wire logic [2:0]  sel_auto_o,
    input wire logic [2:0]  sel_forced_o,
    input wire logic [8:0]  sel_input_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_acc; psel_i && penable_i; endsequence
    property p_ready; s_acc |-> pready_o; endproperty
    property p_misalign;
        s_setup ##0 (!pwrite_i && paddr_i[1:0] != 2'h0) |=> pslverr_o && prdata_o == 32'h0;
    endproperty
    property p_mapped; s_setup ##0 (paddr_i == rcm_pkg::A_SEL) |=> !pslverr_o; endproperty
    property p_sel_wr;
        s_acc ##0 (pwrite_i && paddr_i == rcm_pkg::A_SEL) |-> ##2
            (sel_auto_o[0] == ($past(pwdata_i[3:0], 2) == 4'h0)) && (sel_forced_o[0] ==
            ($past(pwdata_i[3:0], 2) inside {[4'h3:4'h6], 4'h9, 4'ha}));
    endproperty
    property p_sel_excl; (sel_auto_o & sel_forced_o) == 3'h0; endproperty
    property p_sel_num;
        ((sel_input_o[2:0] != 3'h0) == sel_forced_o[0])
            && ((sel_input_o[5:3] != 3'h0) == sel_forced_o[1])
            && ((sel_input_o[8:6] != 3'h0) == sel_forced_o[2]) && sel_input_o[2:0] <= 3'h6;
    endproperty
    property p_refuse_wr;
        s_acc ##0 (pwrite_i && paddr_i == 8'h09) |=> $stable(sel_auto_o) [*2];
    endproperty
    // eight quiet samples exceed the synchroniser and toggle latency
    property p_div_quiet;
        (rst_b_i && $stable(ref_inputs_i)) [*8] |-> $stable(div_clk_o);
    endproperty
    a_ready: assert property (p_ready) else $error("pready low in access phase");
    a_misalign: assert property (p_misalign) else $error("misaligned read not refused");
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    a_sel_wr: assert property (p_sel_wr) else $error("selection code decoded wrongly");
    a_sel_excl: assert property (p_sel_excl) else $error("automatic and forced together");
    a_sel_num: assert property (p_sel_num) else $error("forced input number inconsistent");
    a_refuse_wr: assert property (p_refuse_wr) else $error("refused write changed selection");
    a_div_quiet: assert property (p_div_quiet) else $error("divider toggled without input edge");
endmodule
`default_nettype wire

// [tb/rcm_src_model.sv]
// reference clock sources and dpll1 output clock on the far side of the block
`timescale 1ns/100ps
`default_nettype none
module rcm_src_model (
    input  wire logic [5:0] en_i,
    input  wire logic [7:0] half_ns_i,
    input  wire logic [7:0] dpll_half_ns_i,
    input  wire logic       dpll_en_i,
    output logic      [5:0] ref_o,
    output logic            dpll1_o,
    output logic            ph_o
);
    logic ph = 1'b0;
    logic dph = 1'b0;
    // a zero half period would spin in one time step, so it waits 1 ns instead
    always begin
        #((half_ns_i == 8'h00) ? 1 : half_ns_i);
        ph = ~ph;
    end
    always begin
        #((dpll_half_ns_i == 8'h00) ? 1 : dpll_half_ns_i);
        dph = ~dph;
    end
    // a disabled source stands still low, as a stopped clock does
    assign ref_o = en_i & {6{ph}};
    assign dpll1_o = dpll_en_i & dph;
    assign ph_o = ph;
endmodule
`default_nettype wire

// [tb/rcm_top_bench.sv]
// register-level tests of the pre-dividers, monitors and selection decode
`timescale 1ns/100ps
`default_nettype none
module rcm_top_bench;
    localparam int ACT = 256;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [5:0]  src_en = 6'h00;
    logic        dpll_en = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  div_clk;
    logic [5:0]  qual;
    logic [2:0]  s_auto;
    logic [2:0]  s_forced;
    logic [8:0]  s_input;
    wire logic [5:0] refs;
    wire logic   dpll1;
    wire logic   ph;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    int          edges = 0;
    logic [31:0] rd;
    logic        er;
    rcm_top #(.ACT_PERIOD_CYC(ACT)) dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ref_inputs_i(refs),
        .dpll1_out_i(dpll1), .div_clk_o(div_clk), .ref_qualified_o(qual), .sel_auto_o(s_auto),
        .sel_forced_o(s_forced), .sel_input_o(s_input));
    // 20 ns half period keeps source edges clear of system clock rising edges
    rcm_src_model u_src (.en_i(src_en), .half_ns_i(8'h14), .dpll_half_ns_i(8'h0b),
        .dpll_en_i(dpll_en), .ref_o(refs), .dpll1_o(dpll1), .ph_o(ph));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ph) edges++;
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_err(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t error flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic divchk(input int i, input logic [7:0] a, input logic [31:0] cfg, input int exp);
        int e;
        int g;
        logic v;
        e = edges;
        g = 0;
        apb(1'b1, a, cfg);
        // the first two gaps may straddle the configuration change
        repeat (3) begin
            v = div_clk[i];
            while (div_clk[i] === v) @(posedge ref_clk);
            g = edges - e;
            e = edges;
        end
        chk(g, exp);
    endtask
    task automatic freq(input int ex, input int w, input logic [31:0] mask,
                        input logic [31:0] exp);
        apb(1'b1, 8'h50, ex);
        repeat (w) @(posedge ref_clk);
        apb(1'b0, 8'h54, 32'h0);
        chk(rd & mask, exp);
    endtask
    function automatic logic [4:0] sel_exp(input int c);
        if (c == 0) return 5'h10;
        if (c >= 3 && c <= 6) return {2'b01, 3'(c - 2)};
        if (c == 9 || c == 10) return {2'b01, 3'(c - 4)};
        return 5'h00;
    endfunction
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int n = 0; n < 6; n++) rdchk(8'h54 + 8'(32 * n), 32'h0008_0000);
        chk({26'h0, qual}, 32'h3f);
        $display("reset values done");
        for (int r = 0; r < 16; r++) begin
            apb(1'b1, 8'h40, 32'(r) << 4);
            repeat (4) @(posedge ref_clk);
            chk({31'h0, qual[0]}, {31'h0, r <= 2 || (r >= 9 && r <= 12)});
        end
        $display("target rate codes done");
        // input 1 is left unqualified, so forced picks must ignore qualification
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, rcm_pkg::A_SEL, {20'h0, 4'(c + 2), 4'(c + 1), 4'(c)});
            repeat (3) @(posedge ref_clk);
            for (int d = 0; d < 3; d++) begin
                chk({27'h0, s_auto[d], s_forced[d], s_input[3*d+:3]},
                    {27'h0, sel_exp((c + d) % 16)});
            end
        end
        apb(1'b0, 8'h58, 32'h0);
        chk_err(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h09, 32'h0);
        chk_err(er, 1'b1);
        chk({29'h0, s_auto}, 32'h2);
        rdchk(rcm_pkg::A_SEL, 32'h0000_010f);
        $display("selection and refusal done");
        src_en <= 6'h3f;
        divchk(0, 8'h40, 32'h0, 1);
        divchk(0, 8'h40, 32'h1, 4);
        divchk(0, 8'h40, 32'h2, 5);
        divchk(4, 8'hc0, 32'h1, 1);
        apb(1'b1, 8'h44, 32'h3);
        divchk(0, 8'h40, 32'h4, 1);
        rdchk(8'h44, 32'h3);
        rdchk(8'h48, 32'h0);
        apb(1'b1, 8'h48, 32'h0);
        divchk(0, 8'h40, 32'h4, 4);
        divchk(0, 8'h40, 32'h8, 4);
        apb(1'b1, 8'h4c, 32'h0001_0002);
        divchk(0, 8'h40, 32'h0, 2);
        apb(1'b1, 8'h4c, 32'h0);
        $display("pre-divider done");
        apb(1'b1, rcm_pkg::A_WIN, 32'd99);
        apb(1'b1, 8'h14, 32'h0001_0103);
        apb(1'b1, 8'h40, 32'h0000_0100);
        apb(1'b1, rcm_pkg::A_GLOB, 32'h0000_3ff0);
        freq(15, 300, 32'hffff_ffff, 32'h000c_0005);
        freq(30, 300, 32'hffff_ffff, 32'h0006_0014);
        chk({31'h0, qual[0]}, 32'h0);
        freq(17, 300, 32'hffff_ffff, 32'h0006_0007);
        freq(50, 6 * ACT, 32'hffff_ffff, 32'h0007_0328);
        freq(10, 250, 32'h000f_00ff, 32'h0001_0000);
        chk({31'h0, qual[0]}, 32'h0);
        freq(10, 8 * ACT, 32'hffff_ffff, 32'h0008_0000);
        $display("monitors done");
        dpll_en <= 1'b1;
        apb(1'b1, rcm_pkg::A_GLOB, 32'h0000_3ff1);
        freq(55, 1700, 32'h0002_0000, 32'h0);
        chk({31'h0, rd[7:0] < 8'h04}, 32'h1);
        $display("monitor reference done");
        give_verdict();
    end
endmodule
bind rcm_top rcm_top_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ref_inputs_i(ref_inputs_i),
    .div_clk_o(div_clk_o), .sel_auto_o(sel_auto_o), .sel_forced_o(sel_forced_o),
    .sel_input_o(sel_input_o));
`default_nettype wire
